// ==== rtl/eac_pkg.sv ====
// Shared constants, field positions and state carriers for the EEPROM access controller
package eac_pkg;

   // Widths
   localparam int ADDR_W     = 10;
   localparam int DATA_W     = 8;
   localparam int IO_ADDR_W  = 6;
   localparam int ADDR_LO_W  = 8;
   localparam int ADDR_HI_W  = ADDR_W - ADDR_LO_W;
   localparam int CTRL_RES_W = 4;

   // I/O register offsets
   localparam logic [IO_ADDR_W-1:0] OFS_CONTROL   = 6'h1F;
   localparam logic [IO_ADDR_W-1:0] OFS_DATA      = 6'h20;
   localparam logic [IO_ADDR_W-1:0] OFS_ADDR_LOW  = 6'h21;
   localparam logic [IO_ADDR_W-1:0] OFS_ADDR_HIGH = 6'h22;

   // Control register bit positions
   localparam int BIT_READ_STROBE  = 0;
   localparam int BIT_WRITE_STROBE = 1;
   localparam int BIT_MASTER_WE    = 2;
   localparam int BIT_READY_IRQ_EN = 3;

   // Cycle counts on the CPU clock
   localparam logic [2:0] MWE_WINDOW_CYCLES = 3'h4;
   localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
   localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;

   // Write timing, derived from the 100 MHz clock
   localparam int CLOCK_PERIOD_NS  = 10;
   localparam int WRITE_TIME_NS    = 3_400_000;
   localparam int WRITE_RC_CYCLES  = 27072;
   localparam int WRITE_CLK_CYCLES = WRITE_TIME_NS / CLOCK_PERIOD_NS;
   localparam int RC_TICK_DIV      = WRITE_CLK_CYCLES / WRITE_RC_CYCLES;

   // Reset values
   localparam logic [ADDR_W-1:0] RST_ADDR = 10'h000;
   localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

   // One I/O access from the core
   typedef struct packed {
      logic                 wr;
      logic                 rd;
      logic [IO_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]    wdata;
   } eac_io_req_s;

   // State of the controller, apart from the write timer and the byte store
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] wr_data;
      logic              irq_en;
      logic              mwe;
      logic [2:0]        mwe_cnt;
      logic              wstrobe;
      logic              rstrobe;
      logic [2:0]        stall_cnt;
      logic              stall;
      logic              irq;
      logic [DATA_W-1:0] rdata;
   } eac_top_s;

endpackage : eac_pkg

// ==== rtl/eac_byte_store.sv ====
// Flip-flop byte array standing in for the EEPROM cells
`timescale 1ns/10ps
module eac_byte_store #(
   parameter int AW = 10,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          i_clock,
   // Write port
   input  wire logic          i_wr_en,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [DW-1:0] i_wr_data,
   // Read port
   input  wire logic [AW-1:0] i_rd_addr,
   output logic      [DW-1:0] o_rd_data
);
   localparam int DEPTH = 1 << AW;

   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
   } eac_store_s;

   eac_store_s store_reg;
   eac_store_s store_next;

   always_comb begin
      store_next = store_reg;
      if (i_wr_en) begin
         store_next.mem[i_wr_addr] = i_wr_data;
      end
   end

   // Contents are nonvolatile, so no reset
   always_ff @(posedge i_clock) begin
      store_reg <= store_next;
   end

   assign o_rd_data = store_reg.mem[i_rd_addr];

endmodule : eac_byte_store

// ==== rtl/eac_write_timer.sv ====
// Self-timed write interval counted in RC oscillator ticks
`timescale 1ns/10ps
module eac_write_timer #(
   parameter int RC_DIV    = 12,
   parameter int RC_CYCLES = 27072
) (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst,
   // Control
   input  wire logic i_start,
   output logic      o_done
);
   localparam int DIV_W = $clog2(RC_DIV + 1);
   localparam int CNT_W = $clog2(RC_CYCLES + 1);

   typedef struct packed {
      logic [DIV_W-1:0] div_cnt;
      logic [CNT_W-1:0] rc_cnt;
      logic             busy;
      logic             done;
   } eac_timer_s;

   eac_timer_s tm_reg;
   eac_timer_s tm_next;
   logic       rc_tick;

   // Divider stands in for the RC oscillator, one enable per tick
   always_comb begin
      tm_next      = tm_reg;
      tm_next.done = 1'b0;
      rc_tick      = tm_reg.div_cnt == DIV_W'(RC_DIV - 1);
      if (!tm_reg.busy) begin
         if (i_start) begin
            tm_next.busy    = 1'b1;
            tm_next.div_cnt = '0;
            tm_next.rc_cnt  = '0;
         end
      end else if (rc_tick) begin
         tm_next.div_cnt = '0;
         if (tm_reg.rc_cnt == CNT_W'(RC_CYCLES - 1)) begin // see R17
            tm_next.busy = 1'b0;
            tm_next.done = 1'b1;
         end else begin
            tm_next.rc_cnt = tm_reg.rc_cnt + CNT_W'(1);
         end
      end else begin
         tm_next.div_cnt = tm_reg.div_cnt + DIV_W'(1);
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tm_reg <= '0;
      end else begin
         tm_reg <= tm_next;
      end
   end

   assign o_done = tm_reg.done;

   property p_done_at_count;
      @(posedge i_clock) disable iff (i_rst)
      tm_reg.done |-> $past(tm_reg.rc_cnt) == CNT_W'(RC_CYCLES - 1) && !tm_reg.busy;
   endproperty
   a_done_at_count: assert property (p_done_at_count) else $error("write ended early"); // see R17

endmodule : eac_write_timer

// ==== rtl/eac_controller.sv ====
// EEPROM access controller: I/O registers, write sequencing, read path, stall and ready interrupt
//
// Operation
// (R1) Address high bits 15:10 read zero
// (R2) Ten-bit linear byte address, 0 to 1023
// (R3) Address undefined at reset; software loads it
// (R4) Data register: write source, read result
// (R5) Ready interrupt while enabled and strobe clear
// (R6) Write starts only inside master-enable window
// (R7) Master enable self-clears after four cycles
// (R8) Write strobe programs data at address
// (R9) Software write sequence, strobe within four cycles
// (R10) No EEPROM write while Flash busy
// (R11) Interrupt mid-sequence makes write time out
// (R12) Hardware clears write strobe when done
// (R13) Write start stalls CPU two cycles
// (R14) Read strobe loads byte, stalls four cycles
// (R15) During write: reads ignored, address frozen
// (R16) Software polls write strobe before reading
// (R17) Write lasts 27072 RC oscillator cycles
// (R18) Control bits 7:4 read zero
// (R19) Read strobe clears itself
`timescale 1ns/10ps
module eac_controller
   import eac_pkg::*;
#(
   parameter int WRITE_RC_CYC = eac_pkg::WRITE_RC_CYCLES,
   parameter int RC_DIV       = eac_pkg::RC_TICK_DIV
) (
   // Clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_rst,
   // I/O register access
   input  eac_pkg::eac_io_req_s           i_io,
   output logic [eac_pkg::DATA_W-1:0]     o_io_rdata,
   // Core status
   input  wire logic                      i_flash_selfprog_busy,
   input  wire logic                      i_global_irq_enable,
   // Core control
   output logic                           o_cpu_stall,
   output logic                           o_ready_irq
);
   import eac_pkg::*;

   eac_top_s          st_reg;
   eac_top_s          st_next;
   logic              ctrl_wr;
   logic              start_write;
   logic              start_read;
   logic              write_done;
   logic [DATA_W-1:0] cell_rdata;

   eac_byte_store #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_store (
      .i_clock   (i_clock),
      .i_wr_en   (write_done),
      .i_wr_addr (st_reg.addr),
      .i_wr_data (st_reg.wr_data),
      .i_rd_addr (st_reg.addr),
      .o_rd_data (cell_rdata)
   );

   eac_write_timer #(
      .RC_DIV    (RC_DIV),
      .RC_CYCLES (WRITE_RC_CYC)
   ) u_timer (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_start (start_write),
      .o_done  (write_done)
   );

   always_comb begin
      st_next = st_reg;
      ctrl_wr = i_io.wr && (i_io.addr == OFS_CONTROL);
      // Strobe counts only inside the window; flash busy blocks it outright
      start_write = ctrl_wr && i_io.wdata[BIT_WRITE_STROBE] && st_reg.mwe
                    && !st_reg.wstrobe && !i_flash_selfprog_busy; // see R6, R8, R10
      start_read  = ctrl_wr && i_io.wdata[BIT_READ_STROBE] && !st_reg.wstrobe; // see R15

      // Master enable window; rewriting a one does not stretch it
      if (st_reg.mwe_cnt != 3'h0) begin
         st_next.mwe_cnt = st_reg.mwe_cnt - 3'h1; // see R7
      end
      if (ctrl_wr && i_io.wdata[BIT_MASTER_WE] && !st_reg.mwe) begin
         st_next.mwe_cnt = MWE_WINDOW_CYCLES;
      end
      st_next.mwe = st_next.mwe_cnt != 3'h0;

      if (ctrl_wr) begin
         st_next.irq_en = i_io.wdata[BIT_READY_IRQ_EN];
      end

      // Write strobe: set on start, cleared by the timer
      if (start_write) begin
         st_next.wstrobe = 1'b1;
         st_next.wr_data = st_reg.data; // see R4
      end else if (write_done) begin
         st_next.wstrobe = 1'b0; // see R12
      end

      st_next.rstrobe = start_read; // see R19

      // Address is frozen while a write runs
      if (i_io.wr && !st_reg.wstrobe) begin // see R15
         if (i_io.addr == OFS_ADDR_LOW) begin
            st_next.addr[ADDR_LO_W-1:0] = i_io.wdata; // see R2
         end else if (i_io.addr == OFS_ADDR_HIGH) begin
            st_next.addr[ADDR_W-1:ADDR_LO_W] = i_io.wdata[ADDR_HI_W-1:0]; // see R2
         end
      end

      if (start_read) begin
         st_next.data = cell_rdata; // see R4, R14
      end else if (i_io.wr && i_io.addr == OFS_DATA) begin
         st_next.data = i_io.wdata;
      end

      // CPU stall counter
      if (start_write) begin
         st_next.stall_cnt = WRITE_STALL_CYCLES; // see R13
      end else if (start_read) begin
         st_next.stall_cnt = READ_STALL_CYCLES; // see R14
      end else if (st_reg.stall_cnt != 3'h0) begin
         st_next.stall_cnt = st_reg.stall_cnt - 3'h1;
      end
      st_next.stall = st_next.stall_cnt != 3'h0;

      st_next.irq = st_next.irq_en && !st_next.wstrobe && i_global_irq_enable; // see R5

      if (i_io.rd) begin
         case (i_io.addr)
            OFS_ADDR_LOW:  st_next.rdata = st_reg.addr[ADDR_LO_W-1:0];
            OFS_ADDR_HIGH: st_next.rdata = {{(DATA_W-ADDR_HI_W){1'b0}},
                                            st_reg.addr[ADDR_W-1:ADDR_LO_W]}; // see R1
            OFS_DATA:      st_next.rdata = st_reg.data;
            OFS_CONTROL:   st_next.rdata = {{CTRL_RES_W{1'b0}}, st_reg.irq_en, st_reg.mwe,
                                            st_reg.wstrobe, st_reg.rstrobe}; // see R18
            default:       st_next.rdata = RST_DATA;
         endcase
      end
   end

   // Address has no defined power-up content; zero is one legal pick
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_reg      <= '0;
         st_reg.addr <= RST_ADDR; // see R3
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_io_rdata  = st_reg.rdata;
   assign o_cpu_stall = st_reg.stall;
   assign o_ready_irq = st_reg.irq;

   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_mwe_set;
      ctrl_wr && i_io.wdata[BIT_MASTER_WE] && !st_reg.mwe;
   endsequence
   sequence s_mwe_window;
      st_reg.mwe [*4] ##1 !st_reg.mwe;
   endsequence
   property p_mwe_timeout;
      s_mwe_set |=> s_mwe_window;
   endproperty
   a_mwe_timeout: assert property (p_mwe_timeout) else $error("master enable window not four cycles"); // see R7

   property p_no_write_without_mwe;
      ctrl_wr && i_io.wdata[BIT_WRITE_STROBE] && !st_reg.mwe && !st_reg.wstrobe |=> !st_reg.wstrobe;
   endproperty
   a_no_write_without_mwe: assert property (p_no_write_without_mwe) else $error("write without master enable"); // see R6

   property p_flash_blocks;
      i_flash_selfprog_busy && !st_reg.wstrobe |=> !st_reg.wstrobe;
   endproperty
   a_flash_blocks: assert property (p_flash_blocks) else $error("write started during flash busy"); // see R10

   sequence s_write_stall;
      st_reg.stall [*2] ##1 !st_reg.stall;
   endsequence
   property p_write_stall;
      start_write |=> st_reg.wstrobe ##0 s_write_stall;
   endproperty
   a_write_stall: assert property (p_write_stall) else $error("write stall not two cycles"); // see R13

   sequence s_read_stall;
      st_reg.stall [*4] ##1 !st_reg.stall;
   endsequence
   property p_read_stall;
      start_read |=> s_read_stall;
   endproperty
   a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles"); // see R14

   property p_read_data;
      start_read |=> st_reg.data == $past(cell_rdata) && st_reg.rstrobe ##1 !st_reg.rstrobe;
   endproperty
   a_read_data: assert property (p_read_data) else $error("read byte or strobe wrong"); // see R4, R19

   property p_addr_frozen;
      st_reg.wstrobe |=> $stable(st_reg.addr);
   endproperty
   a_addr_frozen: assert property (p_addr_frozen) else $error("address changed during write"); // see R15

   property p_strobe_clear;
      $fell(st_reg.wstrobe) |-> $past(write_done);
   endproperty
   a_strobe_clear: assert property (p_strobe_clear) else $error("write strobe cleared without timer"); // see R12

   property p_ready_irq;
      st_reg.irq_en && !st_reg.wstrobe && i_global_irq_enable && !ctrl_wr |=> o_ready_irq;
   endproperty
   a_ready_irq: assert property (p_ready_irq) else $error("ready interrupt missing"); // see R5

   property p_reserved_zero;
      i_io.rd && (i_io.addr == OFS_ADDR_HIGH || i_io.addr == OFS_CONTROL) |=> o_io_rdata[7:4] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // see R1, R18

   // Address and data register access
   property p_addr_low_write;
      i_io.wr && i_io.addr == OFS_ADDR_LOW && !st_reg.wstrobe |=> st_reg.addr[ADDR_LO_W-1:0] == $past(i_io.wdata);
   endproperty
   a_addr_low_write: assert property (p_addr_low_write) else $error("address low byte not loaded"); // see R2

   property p_addr_high_write;
      i_io.wr && i_io.addr == OFS_ADDR_HIGH && !st_reg.wstrobe
         |=> st_reg.addr[ADDR_W-1:ADDR_LO_W] == $past(i_io.wdata[ADDR_HI_W-1:0]);
   endproperty
   a_addr_high_write: assert property (p_addr_high_write) else $error("address high bits not loaded"); // see R2

   property p_addr_high_read;
      i_io.rd && i_io.addr == OFS_ADDR_HIGH |=> o_io_rdata[DATA_W-1:ADDR_HI_W] == '0
         && o_io_rdata[ADDR_HI_W-1:0] == $past(st_reg.addr[ADDR_W-1:ADDR_LO_W]);
   endproperty
   a_addr_high_read: assert property (p_addr_high_read) else $error("address high read wrong"); // see R1

   property p_addr_low_read;
      i_io.rd && i_io.addr == OFS_ADDR_LOW |=> o_io_rdata == $past(st_reg.addr[ADDR_LO_W-1:0]);
   endproperty
   a_addr_low_read: assert property (p_addr_low_read) else $error("address low read wrong"); // see R2

   property p_data_write;
      i_io.wr && i_io.addr == OFS_DATA |=> st_reg.data == $past(i_io.wdata);
   endproperty
   a_data_write: assert property (p_data_write) else $error("data register not loaded"); // see R4

   // Write path
   property p_wr_data_latch;
      start_write |=> st_reg.wr_data == $past(st_reg.data);
   endproperty
   a_wr_data_latch: assert property (p_wr_data_latch) else $error("write byte not taken from data register"); // see R4

   property p_wr_data_hold;
      st_reg.wstrobe |=> $stable(st_reg.wr_data);
   endproperty
   a_wr_data_hold: assert property (p_wr_data_hold) else $error("write byte changed during write"); // see R8

   property p_store_write;
      write_done |=> cell_rdata == $past(st_reg.wr_data);
   endproperty
   a_store_write: assert property (p_store_write) else $error("byte not programmed at address"); // see R8

   property p_write_start;
      $rose(st_reg.wstrobe) |-> $past(start_write);
   endproperty
   a_write_start: assert property (p_write_start) else $error("write strobe set without accepted start"); // see R6, R8

   property p_mwe_no_restart;
      ctrl_wr && i_io.wdata[BIT_MASTER_WE] && st_reg.mwe |=> st_reg.mwe_cnt == $past(st_reg.mwe_cnt) - 3'h1;
   endproperty
   a_mwe_no_restart: assert property (p_mwe_no_restart) else $error("master enable window restarted"); // see R7

   // Read path, stall and interrupt
   property p_read_ignored;
      st_reg.wstrobe |=> !st_reg.rstrobe;
   endproperty
   a_read_ignored: assert property (p_read_ignored) else $error("read strobe taken during write"); // see R15

   property p_rstrobe_only_on_read;
      !start_read |=> !st_reg.rstrobe;
   endproperty
   a_rstrobe_only_on_read: assert property (p_rstrobe_only_on_read) else $error("read strobe stuck"); // see R19

   property p_stall_idle;
      st_reg.stall_cnt == 3'h0 && !start_write && !start_read |=> !o_cpu_stall;
   endproperty
   a_stall_idle: assert property (p_stall_idle) else $error("stall without a strobe"); // see R13, R14

   property p_irq_off_in_write;
      st_reg.wstrobe && !write_done |=> !o_ready_irq;
   endproperty
   a_irq_off_in_write: assert property (p_irq_off_in_write) else $error("ready interrupt during write"); // see R5

   property p_irq_needs_gie;
      !i_global_irq_enable |=> !o_ready_irq;
   endproperty
   a_irq_needs_gie: assert property (p_irq_needs_gie) else $error("ready interrupt while globally masked"); // see R5

endmodule : eac_controller

// ==== testbench/eac_controller_bench.sv ====
// Self-checking bench for the EEPROM access controller
`timescale 1ns/10ps
module eac_controller_bench;
   import eac_pkg::*;
   logic        i_clock    = 1'b0;
   logic        i_rst      = 1'b1;
   eac_io_req_s io         = '0;
   logic        busy       = 1'b0;
   logic        gie        = 1'b0;
   logic [7:0]  rdata;
   logic        stall;
   logic        irq;
   logic [7:0]  v;
   int          bad_count  = 0;
   int          num_checks = 0;

   always #5 i_clock = ~i_clock;

   // Short write time keeps the run brief
   eac_controller #(.WRITE_RC_CYC(8), .RC_DIV(2)) eac_controller_inst (
      .i_clock(i_clock), .i_rst(i_rst), .i_io(io), .o_io_rdata(rdata),
      .i_flash_selfprog_busy(busy), .i_global_irq_enable(gie),
      .o_cpu_stall(stall), .o_ready_irq(irq));

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge i_clock);
      io = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge i_clock);
      io.wr = 1'b0;
   endtask : io_wr

   task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge i_clock);
      io = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_clock);
      io.rd = 1'b0;
      d = rdata;
   endtask : io_rd

   // Stall high for n cycles, then low
   task automatic stall_run(input int n);
      repeat (n) begin
         check({7'h00, stall}, 8'h01);
         @(negedge i_clock);
      end
      check({7'h00, stall}, 8'h00);
   endtask : stall_run

   task automatic set_addr(input logic [9:0] a);
      io_wr(OFS_ADDR_LOW, a[7:0]);
      io_wr(OFS_ADDR_HIGH, {6'h00, a[9:8]});
   endtask : set_addr

   task automatic ee_start(input logic [9:0] a, input logic [7:0] d, input logic [7:0] ctl);
      set_addr(a);
      io_wr(OFS_DATA, d);
      io_wr(OFS_CONTROL, 8'h04 | ctl);
      io_wr(OFS_CONTROL, 8'h06 | ctl);
      stall_run(2);
   endtask : ee_start

   // Bounded poll; an X strobe bit ends the loop and fails below
   task automatic wait_idle;
      int k;
      k = 0;
      v = 8'h02;
      while (v[1] === 1'b1 && k < 100) begin
         io_rd(OFS_CONTROL, v);
         k++;
      end
      check({7'h00, v[1]}, 8'h00);
      check(v & 8'hF0, 8'h00);
   endtask : wait_idle

   task automatic ee_read(input logic [9:0] a, input logic [7:0] ctl, output logic [7:0] d);
      wait_idle;
      set_addr(a);
      io_wr(OFS_CONTROL, 8'h01 | ctl);
      stall_run(4);
      io_rd(OFS_DATA, d);
   endtask : ee_read

   initial begin
      #50000;
      bad_count++;
      complete_run;
   end

   initial begin
      repeat (12) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      io_rd(OFS_CONTROL, v);
      check(v, 8'h00);
      check({6'h00, irq, stall}, 8'h00);
      // Address halves, reserved high bits
      set_addr(10'h3FF);
      io_wr(OFS_ADDR_HIGH, 8'hFF);
      io_rd(OFS_ADDR_HIGH, v);
      check(v, 8'h03);
      io_rd(OFS_ADDR_LOW, v);
      check(v, 8'hFF);
      // Both ends of the array, second write disturbed mid-run
      ee_start(10'h000, 8'h3C, 8'h00);
      wait_idle;
      ee_start(10'h3FF, 8'h5A, 8'h00);
      io_wr(OFS_ADDR_LOW, 8'h00);
      io_wr(OFS_DATA, 8'h11);
      io_wr(OFS_CONTROL, 8'h03);
      stall_run(0);
      wait_idle;
      io_rd(OFS_ADDR_LOW, v);
      check(v, 8'hFF);
      io_rd(OFS_DATA, v);
      check(v, 8'h11);
      ee_read(10'h3FF, 8'h00, v);
      check(v, 8'h5A);
      ee_read(10'h000, 8'h00, v);
      check(v, 8'h3C);
      io_rd(OFS_CONTROL, v);
      check(v, 8'h00);
      // Master enable self-clears
      io_wr(OFS_CONTROL, 8'h04);
      io_rd(OFS_CONTROL, v);
      check(v, 8'h04);
      repeat (2) @(negedge i_clock);
      io_rd(OFS_CONTROL, v);
      check(v, 8'h00);
      // Strobe in the last window cycle is taken, one later is not
      set_addr(10'h3FF);
      for (int late = 2; late < 4; late++) begin
         io_wr(OFS_DATA, (late == 2) ? 8'hA5 : 8'h66);
         io_wr(OFS_CONTROL, 8'h04);
         repeat (late) @(negedge i_clock);
         io_wr(OFS_CONTROL, 8'h06);
         check({7'h00, stall}, (late == 2) ? 8'h01 : 8'h00);
         repeat (2) @(negedge i_clock);
         wait_idle;
      end
      ee_read(10'h3FF, 8'h00, v);
      check(v, 8'hA5);
      // Flash self-programming refuses the strobe
      busy = 1'b1;
      io_wr(OFS_DATA, 8'h77);
      io_wr(OFS_CONTROL, 8'h04);
      io_wr(OFS_CONTROL, 8'h06);
      check({7'h00, stall}, 8'h00);
      busy = 1'b0;
      wait_idle;
      ee_read(10'h3FF, 8'h00, v);
      check(v, 8'hA5);
      // Ready interrupt
      gie = 1'b1;
      io_wr(OFS_CONTROL, 8'h08);
      @(negedge i_clock);
      check({7'h00, irq}, 8'h01);
      ee_start(10'h001, 8'h99, 8'h08);
      check({7'h00, irq}, 8'h00);
      wait_idle;
      check({7'h00, irq}, 8'h01);
      gie = 1'b0;
      repeat (2) @(negedge i_clock);
      check({7'h00, irq}, 8'h00);
      gie = 1'b1;
      io_wr(OFS_CONTROL, 8'h00);
      @(negedge i_clock);
      check({7'h00, irq}, 8'h00);
      ee_read(10'h001, 8'h00, v);
      check(v, 8'h99);
      complete_run;
   end
endmodule : eac_controller_bench
